// ### hw/isrd_bus_if.sv
// Two-wire bus between the master end and the slave end.
interface isrd_bus_if;

   logic scl;        // Bus clock, made by the master.
   logic sda_m_out;  // Master data drive value.
   logic sda_m_oe;   // Master drives the data line while high.
   logic sda_s_out;  // Slave data drive value.
   logic sda_s_oe;   // Slave drives the data line while high.
   logic sda;        // Resolved data line level.

   // Open-drain wire with pull-up: any enabled low drive wins.
   assign sda = !((sda_m_oe && !sda_m_out) || (sda_s_oe && !sda_s_out));

   modport host (output scl, output sda_m_out, output sda_m_oe, input sda);
   modport dev  (input scl, input sda, output sda_s_out, output sda_s_oe);

endinterface

// ### hw/isrd_dev.sv
// Slave end: byte memory reached over the two-wire bus, clocked by the bus clock.
module isrd_dev (
   input  wire logic                      clock_in,
   input  wire logic                      arst_n_in,
   isrd_bus_if.dev                        bus,
   output logic                           wr_valid_out,
   output logic [isrd_pkg::PTR_W-1:0]     wr_addr_out,
   output logic [7:0]                     wr_data_out
);
   import isrd_pkg::*;

   // Frame state and bit position within the current byte.
   isrd_dev_st_t        st_r;
   logic [3:0]          cnt_r;
   // Receive shifter, transmit shifter and the byte pointer.
   logic [7:0]          shift_r;
   logic [7:0]          tx_r;
   logic [PTR_W-1:0]    ptr_r;
   // Acknowledge decision and direction bit of the address byte.
   logic                ack_r;
   logic                rw_r;
   // Byte memory held in flip-flops.
   logic [7:0]          mem_r [MEM_DEPTH];
   // START event toggle on the data line and its copy on the bus clock.
   logic                start_tgl_r;
   logic                start_seen_r;
   // Written byte handed to the system clock domain.
   logic                wr_tgl_r;
   logic [PTR_W-1:0]    wr_addr_hold_r;
   logic [7:0]          wr_data_hold_r;
   // Data line drive, changed on the falling bus clock edge only.
   logic                sda_oe_r;
   // Toggle synchroniser in the system clock domain.
   logic [2:0]          wr_sync_r;

   // Combinational decodes.
   logic [7:0]          byte_w;      // Byte including the bit now on the line.
   logic [PTR_W-1:0]    ptr_inc_w;   // Pointer plus one, wrapping naturally.
   logic                start_w;     // A START came since the last rising edge.
   logic                rx_st_w;     // A state that receives bytes.
   logic                byte_end_w;  // Eighth bit of a received byte.
   logic                slot_w;      // Acknowledge slot of any byte.
   logic                go_rd_w;     // Read address acknowledged.
   logic                mack_w;      // Master acknowledged a read byte.
   logic                wr_pulse_w;  // One written byte arrived.

   assign byte_w     = {shift_r[6:0], bus.sda};
   assign ptr_inc_w  = ptr_r + PTR_STEP;
   assign start_w    = start_tgl_r ^ start_seen_r;
   assign rx_st_w    = (st_r == DS_DEVADR) || (st_r == DS_REGADR) || (st_r == DS_WDATA);
   assign byte_end_w = !start_w && rx_st_w && (cnt_r == LAST_DATA_BIT);
   assign slot_w     = !start_w && (st_r != DS_IDLE) && (cnt_r == ACK_SLOT);
   assign go_rd_w    = slot_w && (st_r == DS_DEVADR) && ack_r && (rw_r == RW_READ);
   assign mack_w     = slot_w && (st_r == DS_RDATA) && !bus.sda;

   // The drive value of an open-drain line is always low.
   assign bus.sda_s_out = 1'b0;
   assign bus.sda_s_oe  = sda_oe_r;

   // START detector: the data line falls while the bus clock is high.
   // The bus clock has no rising edge between START and the first data bit, so the
   // toggle is read on the next rising edge; setup time on the bus keeps it
   // settled by then.
   always_ff @(negedge bus.sda or negedge arst_n_in)
   begin
      if (!arst_n_in)
         start_tgl_r <= 1'b0;
      else if (bus.scl)
         start_tgl_r <= ~start_tgl_r;
   end

   // Frame state machine: a START always restarts at the address byte, even
   // in the middle of a write, so a truncated data byte is not stored.
   always_ff @(posedge bus.scl or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         st_r         <= DS_IDLE;
         cnt_r        <= 4'h0;
         shift_r      <= 8'h00;
         start_seen_r <= 1'b0;
      end
      else if (start_w)
      begin
         // The first address bit is on the line at this edge.
         start_seen_r <= start_tgl_r;
         st_r         <= DS_DEVADR;
         cnt_r        <= 4'h1;
         shift_r      <= {7'h00, bus.sda};
      end
      else if (st_r == DS_IDLE)
      begin
         // Waiting for the next START; nothing is sampled.
         cnt_r <= 4'h0;
      end
      else if (cnt_r != ACK_SLOT)
      begin
         // Data bits of the byte, most significant first.
         cnt_r   <= cnt_r + 4'h1;
         shift_r <= byte_w;
      end
      else
      begin
         // Acknowledge slot ends the byte.
         cnt_r <= 4'h0;
         unique case (st_r)
            DS_DEVADR:
               // Not our address: stay off the bus until the next START.
               if (!ack_r)
                  st_r <= DS_IDLE;
               else if (rw_r == RW_READ)
                  st_r <= DS_RDATA;
               else
                  st_r <= DS_REGADR;
            DS_REGADR:
               st_r <= DS_WDATA;
            DS_WDATA:
               st_r <= DS_WDATA;
            DS_RDATA:
               // A high line is the master's NACK: release and go idle.
               st_r <= bus.sda ? DS_IDLE : DS_RDATA;
            DS_IDLE:
               st_r <= DS_IDLE;
         endcase
      end
   end

   // Acknowledge decision, taken at the eighth bit of each received byte.
   always_ff @(posedge bus.scl or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         ack_r <= 1'b0;
         rw_r  <= RW_WRITE;
      end
      else if (byte_end_w)
      begin
         if (st_r == DS_DEVADR)
         begin
            ack_r <= (byte_w[7:1] == DEV_ADDR);
            rw_r  <= byte_w[0];
         end
         else
            ack_r <= 1'b1;
      end
   end

   // Byte pointer: loaded by the register address byte, stepped after each
   // written byte and after each byte sent, so it rests one past the last.
   always_ff @(posedge bus.scl or negedge arst_n_in)
   begin
      if (!arst_n_in)
         ptr_r <= '0;
      else if (byte_end_w && (st_r == DS_REGADR))
         ptr_r <= byte_w;
      else if (byte_end_w && (st_r == DS_WDATA))
         ptr_r <= ptr_inc_w;
      else if (slot_w && (st_r == DS_RDATA))
         ptr_r <= ptr_inc_w;
   end

   // Transmit shifter: loaded with the pointed byte when a read begins or
   // when the master acknowledges, shifted after each bit is taken.
   always_ff @(posedge bus.scl or negedge arst_n_in)
   begin
      if (!arst_n_in)
         tx_r <= 8'h00;
      else if (go_rd_w)
         tx_r <= mem_r[ptr_r];
      else if (mack_w)
         tx_r <= mem_r[ptr_inc_w];
      else if (!start_w && (st_r == DS_RDATA) && (cnt_r != ACK_SLOT))
         tx_r <= {tx_r[6:0], 1'b1};
   end

   // Memory write and hand-over of the written byte; only a complete data
   // byte after the register address is ever stored.
   always_ff @(posedge bus.scl or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         for (int i = 0; i < MEM_DEPTH; i++)
            mem_r[i] <= MEM_RST;
         wr_tgl_r       <= 1'b0;
         wr_addr_hold_r <= '0;
         wr_data_hold_r <= 8'h00;
      end
      else if (byte_end_w && (st_r == DS_WDATA))
      begin
         mem_r[ptr_r]   <= byte_w;
         wr_tgl_r       <= ~wr_tgl_r;
         wr_addr_hold_r <= ptr_r;
         wr_data_hold_r <= byte_w;
      end
   end

   // Data line drive on the falling clock edge, so the line only changes
   // while the clock is low and never fakes a START or STOP.
   always_ff @(negedge bus.scl or negedge arst_n_in)
   begin
      if (!arst_n_in)
         sda_oe_r <= 1'b0;
      else if (st_r == DS_RDATA)
         // Send the data bit; let go in the master's acknowledge slot.
         sda_oe_r <= (cnt_r != ACK_SLOT) && !tx_r[7];
      else
         // Pull low in the ninth clock of an accepted byte.
         sda_oe_r <= rx_st_w && (cnt_r == ACK_SLOT) && ack_r;
   end

   // Written-byte event into the system clock: toggle, two flops, then edge.
   always_ff @(posedge clock_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         wr_sync_r <= 3'h0;
      else
         wr_sync_r <= {wr_sync_r[1:0], wr_tgl_r};
   end

   assign wr_pulse_w = wr_sync_r[2] ^ wr_sync_r[1];

   // User-side strobe; the held byte stays still for a whole bus byte.
   always_ff @(posedge clock_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         wr_valid_out <= 1'b0;
         wr_addr_out  <= '0;
         wr_data_out  <= 8'h00;
      end
      else
      begin
         wr_valid_out <= wr_pulse_w;
         if (wr_pulse_w)
         begin
            wr_addr_out <= wr_addr_hold_r;
            wr_data_out <= wr_data_hold_r;
         end
      end
   end

endmodule

// ### hw/isrd_host.sv
// Master end: writes one byte or reads a run of bytes over the two-wire bus.
module isrd_host (
   input  wire logic           clock_in,
   input  wire logic           arst_n_in,
   isrd_bus_if.host            bus,
   input  wire logic           cmd_valid_in,
   output logic                cmd_ready_out,
   input  wire logic           cmd_read_in,
   input  wire logic [7:0]     cmd_reg_in,
   input  wire logic [7:0]     cmd_wdata_in,
   input  wire logic [7:0]     cmd_len_in,
   output logic                rd_valid_out,
   output logic [7:0]          rd_data_out,
   output logic                done_out,
   output logic                nack_out
);
   import isrd_pkg::*;

   isrd_host_st_t st_r;        // Sequence state.
   logic [9:0]    qcnt_r;      // Cycles within a quarter bit.
   logic [1:0]    ph_r;        // Quarter of the current symbol.
   logic [3:0]    bit_r;       // Bit within a byte, 8 is the acknowledge.
   logic [8:0]    tx_r;        // Byte plus acknowledge bit to send.
   logic [8:0]    rx_r;        // Sampled byte plus acknowledge bit.
   logic          rd_r;        // Command is a read.
   logic [7:0]    reg_r;       // Register address of the command.
   logic [7:0]    wd_r;        // Write data of the command.
   logic [7:0]    left_r;      // Read bytes still to come.
   logic          scl_r;       // Bus clock level.
   logic          sda_r;       // Data line level released (high) or pulled.
   logic [1:0]    sda_sync_r;  // Two-flop synchroniser of the data line.

   logic          q_end_w;     // Last cycle of a quarter.
   logic          sym_end_w;   // Last cycle of a symbol.
   logic          byte_st_w;   // State that moves a byte.
   logic          nack_w;      // Far end left the acknowledge high.

   assign cmd_ready_out = (st_r == HS_IDLE);
   assign q_end_w   = (qcnt_r == QTR_LAST);
   assign sym_end_w = q_end_w && (ph_r == 2'h3) && (st_r != HS_IDLE);
   assign byte_st_w = (st_r == HS_DEVW) || (st_r == HS_REG) || (st_r == HS_DATA) ||
                      (st_r == HS_DEVR) || (st_r == HS_READ);
   assign nack_w    = rx_r[0];

   assign bus.scl       = scl_r;
   assign bus.sda_m_out = 1'b0;
   assign bus.sda_m_oe  = !sda_r;

   // Bus levels {clock, data} for each quarter of the current symbol.
   function automatic logic [1:0] lvl(input isrd_host_st_t st, input logic [1:0] ph,
                                       input logic b);
      lvl = 2'b11;
      if ((st == HS_START) || (st == HS_RSTART))
         lvl = (ph == 2'h0) ? 2'b01 : (ph == 2'h1) ? 2'b11 : (ph == 2'h2) ? 2'b10 : 2'b00;
      else if (st == HS_STOP)
         lvl = (ph == 2'h0) ? 2'b00 : (ph == 2'h1) ? 2'b10 : 2'b11;
      else if (st != HS_IDLE)
         lvl = {(ph == 2'h1) || (ph == 2'h2), b};
   endfunction

   // Quarter-bit divider; it makes the bus clock and runs only while busy.
   always_ff @(posedge clock_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         qcnt_r <= 10'h000;
         ph_r   <= 2'h0;
      end
      else if (st_r == HS_IDLE)
      begin
         qcnt_r <= 10'h000;
         ph_r   <= 2'h0;
      end
      else
      begin
         qcnt_r <= q_end_w ? 10'h000 : qcnt_r + 10'h001;
         if (q_end_w)
            ph_r <= ph_r + 2'h1;
      end
   end

   // Bus pin levels from flip-flops.
   always_ff @(posedge clock_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         {scl_r, sda_r} <= 2'b11;
      else
         {scl_r, sda_r} <= lvl(st_r, ph_r, tx_r[8]);
   end

   // Data line synchroniser and sampling at the end of the first clock-high quarter.
   always_ff @(posedge clock_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         sda_sync_r <= 2'b11;
         rx_r       <= 9'h000;
      end
      else
      begin
         sda_sync_r <= {sda_sync_r[0], bus.sda};
         if (q_end_w && (ph_r == 2'h1) && byte_st_w)
            rx_r <= {rx_r[7:0], sda_sync_r[1]};
      end
   end

   // Sequence: START, address+write, register, then either data and STOP,
   // or repeated START, address+read and a run of read bytes.
   always_ff @(posedge clock_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         st_r     <= HS_IDLE;
         bit_r    <= 4'h0;
         tx_r     <= 9'h1FF;
         rd_r     <= 1'b0;
         reg_r    <= 8'h00;
         wd_r     <= 8'h00;
         left_r   <= 8'h00;
         nack_out <= 1'b0;
      end
      else if (st_r == HS_IDLE)
      begin
         if (cmd_valid_in)
         begin
            st_r     <= HS_START;
            rd_r     <= cmd_read_in;
            reg_r    <= cmd_reg_in;
            wd_r     <= cmd_wdata_in;
            left_r   <= cmd_len_in;
            nack_out <= 1'b0;
         end
      end
      else if (sym_end_w && byte_st_w && (bit_r != ACK_SLOT))
      begin
         bit_r <= bit_r + 4'h1;
         tx_r  <= {tx_r[7:0], 1'b1};
      end
      else if (sym_end_w)
      begin
         bit_r <= 4'h0;
         unique case (st_r)
            HS_START:
            begin
               st_r <= HS_DEVW;
               tx_r <= {DEV_ADDR, RW_WRITE, 1'b1};
            end
            HS_DEVW:
               if (nack_w)
               begin
                  st_r     <= HS_STOP;
                  nack_out <= 1'b1;
               end
               else
               begin
                  st_r <= HS_REG;
                  tx_r <= {reg_r, 1'b1};
               end
            HS_REG:
               if (nack_w)
               begin
                  st_r     <= HS_STOP;
                  nack_out <= 1'b1;
               end
               else if (rd_r)
                  st_r <= HS_RSTART;
               else
               begin
                  st_r <= HS_DATA;
                  tx_r <= {wd_r, 1'b1};
               end
            HS_DATA:
            begin
               st_r     <= HS_STOP;
               nack_out <= nack_w;
            end
            HS_RSTART:
            begin
               st_r <= HS_DEVR;
               tx_r <= {DEV_ADDR, RW_READ, 1'b1};
            end
            HS_DEVR:
               if (nack_w)
               begin
                  st_r     <= HS_STOP;
                  nack_out <= 1'b1;
               end
               else
               begin
                  st_r <= HS_READ;
                  tx_r <= {RELEASE_BYTE, left_r == 8'h01};
               end
            HS_READ:
            begin
               left_r <= left_r - 8'h01;
               if (left_r == 8'h01)
                  st_r <= HS_STOP;
               else
                  tx_r <= {RELEASE_BYTE, left_r == 8'h02};
            end
            HS_STOP:
               st_r <= HS_IDLE;
            HS_IDLE:
               st_r <= HS_IDLE;
         endcase
      end
   end

   // Read byte strobe and end-of-command strobe.
   always_ff @(posedge clock_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         rd_valid_out <= 1'b0;
         rd_data_out  <= 8'h00;
         done_out     <= 1'b0;
      end
      else
      begin
         rd_valid_out <= sym_end_w && (st_r == HS_READ) && (bit_r == ACK_SLOT);
         done_out     <= sym_end_w && (st_r == HS_STOP);
         if (sym_end_w && (st_r == HS_READ) && (bit_r == ACK_SLOT))
            rd_data_out <= rx_r[8:1];
      end
   end

endmodule

// ### hw/isrd_pkg.sv
// Shared constants and types of the byte-addressed I2C read link.
package isrd_pkg;

   // Seven-bit bus address that the slave answers to.
   localparam logic [6:0]  DEV_ADDR      = 7'h69;
   // Width of the byte pointer and depth of the byte memory.
   localparam int unsigned PTR_W         = 8;
   localparam int unsigned MEM_DEPTH     = 256;
   // Bit counter value at the eighth data bit and at the acknowledge slot.
   localparam logic [3:0]  LAST_DATA_BIT = 4'h7;
   localparam logic [3:0]  ACK_SLOT      = 4'h8;
   // Read/write bit values of the address byte.
   localparam logic        RW_WRITE      = 1'b0;
   localparam logic        RW_READ       = 1'b1;
   // Pointer step and memory reset value.
   localparam logic [7:0]  PTR_STEP      = 8'h01;
   localparam logic [7:0]  MEM_RST       = 8'h00;
   // All-ones byte the master sends while it only listens.
   localparam logic [7:0]  RELEASE_BYTE  = 8'hFF;
   // System clock and bus clock rates, and the quarter bit time in cycles.
   localparam int unsigned CLK_KHZ       = 200000;
   localparam int unsigned SCL_KHZ       = 100;
   localparam int unsigned QTR_CYC       = CLK_KHZ / (SCL_KHZ * 4);
   localparam logic [9:0]  QTR_LAST      = 10'(QTR_CYC - 1);

   // Slave frame states, stepped on the bus clock.
   typedef enum {DS_IDLE, DS_DEVADR, DS_REGADR, DS_WDATA, DS_RDATA} isrd_dev_st_t;
   // Master sequence states, stepped on the system clock.
   typedef enum {HS_IDLE, HS_START, HS_DEVW, HS_REG, HS_DATA, HS_RSTART,
                 HS_DEVR, HS_READ, HS_STOP} isrd_host_st_t;

endpackage

// ### testbench/isrd_bus_sva.sv
// Checker of the shared two-wire bus between the master end and the slave end.
module isrd_bus_sva (
   input wire logic clock_in,   // System clock.
   input wire logic arst_n_in,  // Asynchronous reset, active low.
   input wire logic scl,        // Bus clock.
   input wire logic sda_m_out,  // Master drive value.
   input wire logic sda_m_oe,   // Master drive enable.
   input wire logic sda_s_out,  // Slave drive value.
   input wire logic sda_s_oe,   // Slave drive enable.
   input wire logic sda         // Resolved data line.
);
   timeunit 1ns;
   timeprecision 1ps;

   logic       scl_q;  // Bus clock one cycle back.
   logic       sda_q;  // Data line one cycle back.
   logic [7:0] cnt_r;  // Bus clock rises since the last START.
   logic       rw_r;   // Read/write bit of the current frame.
   logic [10:0] ack_cyc_r;  // Cycles the write address acknowledge has been driven.

   // Ceiling of the write address acknowledge drive, 1200 system cycles.
   localparam logic [10:0] ACK_MAX = 11'h4B0;

   // Keeps the wires one cycle back so that edges and conditions can be found.
   always_ff @(posedge clock_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end
      else
      begin
         scl_q <= scl;
         sda_q <= sda;
      end
   end

   // Counts clock rises in a frame; a START clears it and it saturates.
   always_ff @(posedge clock_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         cnt_r <= 8'h00;
      else if (scl && scl_q && sda_q && !sda)
         cnt_r <= 8'h00;
      else if (scl && !scl_q && cnt_r != 8'hFF)
         cnt_r <= cnt_r + 8'h01;
   end

   // Captures the line at the eighth rise, which carries the read/write bit.
   always_ff @(posedge clock_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         rw_r <= 1'b0;
      else if (scl && !scl_q && cnt_r == 8'h07)
         rw_r <= sda;
   end

   // Counts how long the slave keeps its drive after the address acknowledge of a
   // write frame; it stops at the ceiling so that a stuck drive stays visible.
   always_ff @(posedge clock_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         ack_cyc_r <= 11'h000;
      else if (!sda_s_oe)
         ack_cyc_r <= 11'h000;
      else if (scl && !scl_q && cnt_r == 8'h08 && !rw_r)
         ack_cyc_r <= 11'h001;
      else if (ack_cyc_r != 11'h000 && ack_cyc_r != ACK_MAX)
         ack_cyc_r <= ack_cyc_r + 11'h001;
   end

   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!arst_n_in);

   // Bus conditions and numbered clock rises of a frame.
   sequence s_start; scl && $past(scl) && $fell(sda); endsequence
   sequence s_stop; scl && $past(scl) && $rose(sda); endsequence
   sequence s_rise(logic [7:0] n, logic w); $rose(scl) && cnt_r == n && rw_r == w; endsequence

   property p_start_free; s_start |-> !sda_s_oe; endproperty
   property p_stop_free; s_stop |-> !sda_s_oe; endproperty
   property p_slv_hold; scl && $past(scl) |-> $stable(sda_s_oe); endproperty
   property p_addr_ack; $rose(scl) && cnt_r == 8'h08 |-> !sda && sda_s_oe; endproperty
   property p_wr_ack; s_rise(8'h11, 1'b0) or s_rise(8'h1A, 1'b0) |-> !sda && sda_s_oe; endproperty
   property p_ack_end; s_rise(8'h08, 1'b0) |-> ##1 ack_cyc_r != ACK_MAX; endproperty
   property p_wr_quiet;
      $rose(scl) && !rw_r && cnt_r inside {[8'h09:8'h10], [8'h12:8'h19]} |-> !sda_s_oe;
   endproperty
   property p_rd_free; $rose(scl) && rw_r && cnt_r inside {[8'h09:8'h10]} |-> !sda_m_oe; endproperty
   property p_rd_ack_slot; s_rise(8'h11, 1'b1) |-> !sda_s_oe; endproperty

   a_start_free: assert property (p_start_free) else $error("slave drives at START");
   a_stop_free: assert property (p_stop_free) else $error("slave drives at STOP");
   a_slv_hold: assert property (p_slv_hold) else $error("slave data moved with clock high");
   a_addr_ack: assert property (p_addr_ack) else $error("address not acknowledged");
   a_wr_ack: assert property (p_wr_ack) else $error("written byte not acknowledged");
   a_ack_end: assert property (p_ack_end) else $error("slave acknowledge not released");
   a_ack_cap: assert property (ack_cyc_r != ACK_MAX) else $error("slave acknowledge held");
   a_wr_quiet: assert property (p_wr_quiet) else $error("slave drives in a write byte");
   a_rd_free: assert property (p_rd_free) else $error("master drives in a read byte");
   a_rd_ack_slot: assert property (p_rd_ack_slot) else $error("slave drives master ack");

   // The read frame's master acknowledge slot is reached.
   c_rd_ack: cover property (s_rise(8'h11, 1'b1));
endmodule

// ### testbench/tb.sv
// Testbench joining the master end and the slave end over the two-wire bus.
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import isrd_pkg::*;

   localparam int LIMIT = 190000;  // Cycle ceiling: one write and one two-byte read.

   logic       clock_in     = 1'b0;   // System clock.
   logic       arst_n_in    = 1'b0;   // Reset, active low.
   logic       cmd_valid_in = 1'b0;   // Command offered.
   logic       cmd_read_in  = 1'b0;   // Read when high.
   logic [7:0] cmd_reg_in   = 8'h00;  // Register address.
   logic [7:0] cmd_wdata_in = 8'h00;  // Write data.
   logic [7:0] cmd_len_in   = 8'h01;  // Bytes to read.
   logic       cmd_ready_out;         // Master idle.
   logic       rd_valid_out;          // Read byte pulse.
   logic [7:0] rd_data_out;           // Read byte.
   logic       done_out;              // Command finished.
   logic       nack_out;              // Slave refused a byte.
   logic       wr_valid_out;          // Slave stored a byte.
   logic [7:0] wr_addr_out;           // Address of the stored byte.
   logic [7:0] wr_data_out;           // Stored byte.
   logic [7:0] rd_q[$];               // Bytes read, in order.
   logic [7:0] model[MEM_DEPTH];      // Expected slave memory.
   logic [7:0] wr_addr_seen;          // Last stored address.
   logic [7:0] wr_data_seen;          // Last stored byte.
   logic [7:0] d;                     // Random write byte.
   int         wr_cnt   = 0;          // Stored bytes seen.
   int         cycles   = 0;          // Clock cycles run.
   int         bad_count = 0;         // Mismatches.
   int         compares = 0;          // Comparisons made.

   // Clock of 5 ns period.
   always #2.5 clock_in = ~clock_in;

   isrd_bus_if i_isrd_bus_if ();

   isrd_host i_isrd_host (.clock_in(clock_in), .arst_n_in(arst_n_in), .bus(i_isrd_bus_if),
      .cmd_valid_in(cmd_valid_in), .cmd_ready_out(cmd_ready_out), .cmd_read_in(cmd_read_in),
      .cmd_reg_in(cmd_reg_in), .cmd_wdata_in(cmd_wdata_in), .cmd_len_in(cmd_len_in),
      .rd_valid_out(rd_valid_out), .rd_data_out(rd_data_out), .done_out(done_out),
      .nack_out(nack_out));

   isrd_dev i_isrd_dev (.clock_in(clock_in), .arst_n_in(arst_n_in), .bus(i_isrd_bus_if),
      .wr_valid_out(wr_valid_out), .wr_addr_out(wr_addr_out), .wr_data_out(wr_data_out));

   isrd_bus_sva i_isrd_bus_sva (.clock_in(clock_in), .arst_n_in(arst_n_in),
      .scl(i_isrd_bus_if.scl), .sda_m_out(i_isrd_bus_if.sda_m_out),
      .sda_m_oe(i_isrd_bus_if.sda_m_oe), .sda_s_out(i_isrd_bus_if.sda_s_out),
      .sda_s_oe(i_isrd_bus_if.sda_s_oe), .sda(i_isrd_bus_if.sda));

   // Prints the counts and the verdict, then ends the run.
   task automatic finish_test();
      $display("mismatches %0d comparisons %0d", bad_count, compares);
      if (bad_count == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Compares a seen byte with the expected one.
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Expected content of one slave byte.
   function automatic logic [7:0] exp_byte(input logic [7:0] a);
      return model[a];
   endfunction

   // Offers one command for a cycle and waits for its completion pulse.
   task automatic run_cmd(input logic rd, input logic [7:0] ra, input logic [7:0] wd,
                          input logic [7:0] len);
      int n;
      n = 0;
      @(negedge clock_in);
      cmd_read_in  = rd;
      cmd_reg_in   = ra;
      cmd_wdata_in = wd;
      cmd_len_in   = len;
      cmd_valid_in = 1'b1;
      @(negedge clock_in);
      cmd_valid_in = 1'b0;
      while (done_out !== 1'b1 && n < LIMIT)
      begin
         @(negedge clock_in);
         n++;
      end
   endtask

   // Watches the user outputs at the falling edge, where they are settled, and
   // cuts a hang short.
   always @(negedge clock_in)
   begin
      cycles = cycles + 1;
      if (rd_valid_out === 1'b1)
         rd_q.push_back(rd_data_out);
      if (wr_valid_out === 1'b1)
      begin
         wr_cnt++;
         wr_addr_seen = wr_addr_out;
         wr_data_seen = wr_data_out;
      end
      if (cycles == LIMIT)
      begin
         bad_count++;
         finish_test();
      end
   end

   // Writes a random byte at the top address, then reads across the wrap.
   initial
   begin
      foreach (model[i]) model[i] = MEM_RST;
      d = 8'($urandom(32'hce10));
      repeat (2) @(posedge clock_in);
      @(negedge clock_in);
      arst_n_in = 1'b1;
      d = 8'($urandom());
      run_cmd(RW_WRITE, 8'hFF, d, 8'h01);
      model[8'hFF] = d;
      check({7'h00, nack_out}, 8'h00);
      check(8'(wr_cnt), 8'h01);
      check(wr_addr_seen, 8'hFF);
      check(wr_data_seen, d);
      run_cmd(RW_READ, 8'hFF, 8'h00, 8'h02);
      check({7'h00, nack_out}, 8'h00);
      check(8'(rd_q.size()), 8'h02);
      check(rd_q[0], exp_byte(8'hFF));
      check(rd_q[1], exp_byte(8'h00));
      check(8'(wr_cnt), 8'h01);
      check({7'h00, cmd_ready_out}, 8'h01);
      finish_test();
   end
endmodule
